// File: common/gli_regs.vh
// constants for the gpio and indicator pin block
// Summary of operation
// RL1: each of three pins is set by software as input, push-pull or open-drain.
// RL2: a pin in indicator mode only pulls low or releases, never drives high.
// RL3: speed indicator is low at 100 Mbit, during negotiation and with no cable.
// RL4: speed indicator is released high only at 10 Mbit.
// RL5: link/activity indicator is low while link is valid and no pulse runs.
// RL6: activity releases the link/activity indicator high for 80 ms.
// RL7: after each off pulse it stays low at least 80 ms; pulsing repeats.
// RL8: duplex indicator is low while the link is full duplex.
// RL9: duplex indicator is high in half duplex or with no link.
// RL10: the 80 ms intervals come from a reset-cleared counter on the device clock.
`ifndef GLI_REGS_VH
`define GLI_REGS_VH
`define GLI_NUM_PINS      3
`define GLI_MODE_INPUT    2'h0
`define GLI_MODE_PUSHPULL 2'h1
`define GLI_MODE_OPENDRN  2'h2
`define GLI_MODE_LED      2'h3
`define GLI_CLK_HZ        125000000
`define GLI_PULSE_MS      80
`define GLI_PULSE_CYCLES  ((`GLI_CLK_HZ / 1000) * `GLI_PULSE_MS)
`define GLI_CNT_W         24
`endif

// File: testbench/gli_checker.sv
// assertions on the pin block ports
`timescale 1ns/10ps
module gli_checker(input wire logic clk,nrst,link_up,link_100,autoneg_busy,full_duplex,
   input wire logic [5:0] pin_mode,input wire logic [2:0] gpio_out,indicator_pins_out,indicator_pins_oe);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire led=pin_mode==6'h3F;
   wire [2:0] oe=indicator_pins_oe;
   a_speed_low: assert property ((led&&(link_100||autoneg_busy||!link_up))[*3] |-> oe[0])
      else $error("speed lamp off");
   a_speed_high: assert property ((led&&link_up&&!link_100&&!autoneg_busy)[*3] |-> !oe[0])
      else $error("speed lamp on");
   a_duplex_low: assert property ((led&&link_up&&full_duplex)[*3] |-> oe[2]) else $error("duplex off");
   a_duplex_high: assert property ((led&&!(link_up&&full_duplex))[*3] |-> !oe[2]) else $error("duplex on");
   a_pulse_off: assert property ($fell(oe[1]) ##0 (led&&link_up)[*8] |-> !oe[1]) else $error("short off");
   a_hold_on: assert property ($rose(oe[1])&&$past(link_up,2)&&$past(led,2) ##0 (led&&link_up)[*8] |-> oe[1])
      else $error("short on");
   a_push_pull: assert property (pin_mode[1:0]==2'h1 |=> oe[0]&&indicator_pins_out[0]==$past(gpio_out[0]))
      else $error("push-pull");
   a_open_drain: assert property (pin_mode[3:2]==2'h2 |=> oe[1]==!$past(gpio_out[1])&&!indicator_pins_out[1])
      else $error("open-drain");
   a_led_drain: assert property (led[*2] |-> indicator_pins_out==3'h0) else $error("led drives high");
endmodule
bind gli_top gli_checker i_chk(.*);

// File: testbench/gli_led_board.sv
// board model: lamps with pull-ups on the three indicator pins
`timescale 1ns/10ps
module gli_led_board(input wire logic [2:0] oe,out,ext_lo,output wire logic [2:0] lvl);
   // a released pin floats up through the lamp; ext_lo is a jumper to ground
   assign lvl=(oe&out)|(~oe&~ext_lo);
endmodule

// File: testbench/gli_top_tb.sv
// testbench for the gpio and indicator pin block
`timescale 1ns/10ps
module gli_top_tb;
   reg clk=0,nrst=0,lu=0,l100=0,an=0,fd=0,act=0;
   reg [5:0] md=6'h3F;
   reg [2:0] go=3'h0,xl=3'h0;
   wire [2:0] gi,po,oe,lvl;
   int bad_count=0,checks=0,cyc=0;
   // {link, 100M, negotiating, full duplex, expected drive enables}
   reg [6:0] rows[6]='{7'h01,7'h63,7'h42,7'h53,7'h4E,7'h09};
   gli_top i_dut(.clk(clk),.nrst(nrst),.pin_mode(md),.gpio_out(go),.gpio_in(gi),.link_up(lu),.link_100(l100),
      .autoneg_busy(an),.full_duplex(fd),.activity(act),.indicator_pins_in(lvl),.indicator_pins_out(po),
      .indicator_pins_oe(oe));
   gli_led_board i_brd(.oe(oe),.out(po),.ext_lo(xl),.lvl(lvl));
   initial forever #4 clk=~clk;
   always @(posedge clk) if(++cyc==3000) begin
      bad_count++;
      close_out;
   end
   task w(int n); repeat(n) @(posedge clk); endtask
   // compare at the falling edge so registered outputs have settled
   task ck(input [2:0] g,e); @(negedge clk); checks++; if(g!==e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h",$time,g,e);
   end endtask
   task close_out; $display("checks %0d bad %0d",checks,bad_count);
      if(bad_count==0&&checks>0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      w(3); ck(oe,3'h0);
      w(1); nrst<=1;
      foreach(rows[i]) begin
         w(1); {lu,l100,an,fd}<=rows[i][6:3]; w(3); ck(oe,rows[i][2:0]);
      end
      ck(po,3'h0);
      // pin0 push-pull high, pin1 open-drain low, pin2 input pulled to ground
      w(1); md<=6'h09; go<=3'h1; xl<=3'h4; w(5); ck(oe,3'h3);
      ck(po,3'h1);
      ck(gi,3'h1);
      // activity with no link must not start a pulse
      w(1); md<=6'h3F; {lu,l100,an,fd}<=4'h0; act<=1; w(4); ck(oe,3'h1);
      w(1); act<=0; lu<=1; w(4); ck(oe,3'h2);
      w(1); act<=1; w(1); act<=0; w(4); ck(oe,3'h0);
      w(200); ck(oe,3'h0);
      w(1); fd<=1; nrst<=0; w(2); ck(oe,3'h0);
      w(1); nrst<=1; w(3); ck(oe,3'h6);
      close_out;
   end
endmodule

// File: verilog/gli_pin.v
// one multiplexed gpio / indicator pin
`timescale 1ns/10ps
`include "gli_regs.vh"
module gli_pin (
   input  wire       clk,
   input  wire       nrst,
   input  wire [1:0] mode,
   input  wire       gpio_out,
   input  wire       indicator_n,
   input  wire       pin_in,
   output reg        pin_out,
   output reg        pin_oe,
   output wire       gpio_in
);
   reg sync1;
   reg sync2;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1   <= 1'b0;
         sync2   <= 1'b0;
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         case (mode)
            `GLI_MODE_INPUT: begin
               pin_out <= 1'b0;
               pin_oe  <= 1'b0; // RL1
            end
            `GLI_MODE_PUSHPULL: begin
               pin_out <= gpio_out;
               pin_oe  <= 1'b1; // RL1
            end
            `GLI_MODE_OPENDRN: begin
               pin_out <= 1'b0;
               pin_oe  <= ~gpio_out; // RL1
            end
            `GLI_MODE_LED: begin
               pin_out <= 1'b0;
               pin_oe  <= ~indicator_n; // RL2
            end
            default: begin
               pin_out <= 1'b0;
               pin_oe  <= 1'b0;
            end
         endcase
      end
   end

   assign gpio_in = sync2;
endmodule

// File: verilog/gli_top.v
// three gpio pins multiplexed with link status indicators
`timescale 1ns/10ps
`include "gli_regs.vh"
module gli_top (
   input  wire       clk,
   input  wire       nrst,
   input  wire [5:0] pin_mode,
   input  wire [2:0] gpio_out,
   output reg  [2:0] gpio_in,
   input  wire       link_up,
   input  wire       link_100,
   input  wire       autoneg_busy,
   input  wire       full_duplex,
   input  wire       activity,
   input  wire [2:0] indicator_pins_in,
   output wire [2:0] indicator_pins_out,
   output wire [2:0] indicator_pins_oe
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_OFF  = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;

   // timer limits are worked out as integers, then cut to the counter widths
   // one tick per millisecond, the intervals count whole ticks
   localparam integer          TICK_LAST_I = (`GLI_CLK_HZ / 1000) - 1;
   localparam integer          MS_LAST_I   = `GLI_PULSE_MS - 1;
   localparam [`GLI_CNT_W-1:0] TICK_LAST   = TICK_LAST_I[`GLI_CNT_W-1:0];
   localparam [6:0]            MS_LAST     = MS_LAST_I[6:0];

   ////////////////////////////////////////////////////////////////////////
   // status inputs come from the phy core on this clock, no sync needed
   reg  [1:0]            state;
   reg  [1:0]            next_state;

   // millisecond enable and the interval count
   reg  [`GLI_CNT_W-1:0] div_cnt;
   reg  [6:0]            ms_cnt;
   wire                  ms_tick;
   wire                  interval_done;
   wire                  state_change;

   // activity seen during the low hold starts the next off pulse
   reg                   act_seen;
   wire                  act_start;

   // decoded link status
   wire                  speed_10;
   wire                  full_link;
   wire                  pulse_off;
   wire                  pulse_hold;

   wire [2:0]            gpio_sync;
   wire [2:0]            ind_n;
   reg                   speed_indicator_n;
   reg                   link_activity_indicator_n;
   reg                   duplex_indicator_n;

   ////////////////////////////////////////////////////////////////////////
   // indicator decode; every indicator is active low
   assign speed_10   = link_up && !autoneg_busy && !link_100;
   assign full_link  = link_up && full_duplex;
   assign pulse_off  = (state == ST_OFF);
   assign pulse_hold = (state == ST_HOLD);

   // negotiation and a missing cable count as not 10M, so the lamp stays on
   always @* begin
      if (speed_10) begin
         speed_indicator_n = 1'b1; // RL4
      end else begin
         speed_indicator_n = 1'b0; // RL3
      end
   end

   always @* begin
      if (!link_up) begin
         link_activity_indicator_n = 1'b1;
      end else if (pulse_off) begin
         link_activity_indicator_n = 1'b1; // RL6
      end else begin
         link_activity_indicator_n = 1'b0; // RL5
      end
   end

   always @* begin
      if (full_link) begin
         duplex_indicator_n = 1'b0; // RL8
      end else begin
         duplex_indicator_n = 1'b1; // RL9
      end
   end

   assign ind_n = {duplex_indicator_n, link_activity_indicator_n, speed_indicator_n};

   ////////////////////////////////////////////////////////////////////////
   // activity pulse timer
   // a millisecond enable keeps the interval counter narrow; the divider
   // restarts on each state change so every interval is exactly whole ticks
   assign ms_tick       = (state != ST_IDLE) && (div_cnt == TICK_LAST);
   assign interval_done = ms_tick && (ms_cnt == MS_LAST); // RL6 RL7
   assign act_start     = link_up && (activity || act_seen);
   assign state_change  = (next_state != state);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (act_start) begin
               next_state = ST_OFF; // RL6
            end
         end
         ST_OFF: begin
            if (interval_done) begin
               next_state = ST_HOLD; // RL6
            end
         end
         ST_HOLD: begin
            if (interval_done) begin
               next_state = ST_IDLE; // RL7
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // a lost link ends any pulse at once
      if (!link_up) begin
         next_state = ST_IDLE;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE; // RL10
      end else begin
         state <= next_state;
      end
   end

   // divider for the millisecond enable
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= {`GLI_CNT_W{1'b0}}; // RL10
      end else if (state_change || state == ST_IDLE || ms_tick) begin
         div_cnt <= {`GLI_CNT_W{1'b0}};
      end else begin
         div_cnt <= div_cnt + 1'b1; // RL10
      end
   end

   // milliseconds spent in the current interval
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ms_cnt <= 7'h00; // RL10
      end else if (state_change || state == ST_IDLE) begin
         ms_cnt <= 7'h00;
      end else if (ms_tick) begin
         ms_cnt <= ms_cnt + 1'b1; // RL10
      end
   end

   // activity during the off pulse is ignored, during the low hold remembered
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_seen <= 1'b0;
      end else if (state == ST_IDLE || !link_up) begin
         act_seen <= 1'b0;
      end else if (activity && pulse_hold) begin
         act_seen <= 1'b1; // RL7
      end
   end

   // one more register after the synchroniser
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_in <= 3'h0;
      end else begin
         gpio_in <= gpio_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers
   // pin 0 carries the speed indicator
   gli_pin u_pin0 (
      .clk         (clk),
      .nrst        (nrst),
      .mode        (pin_mode[1:0]),
      .gpio_out    (gpio_out[0]),
      .indicator_n (ind_n[0]),
      .pin_in      (indicator_pins_in[0]),
      .pin_out     (indicator_pins_out[0]),
      .pin_oe      (indicator_pins_oe[0]),
      .gpio_in     (gpio_sync[0])
   );

   // pin 1 carries the link/activity indicator
   gli_pin u_pin1 (
      .clk         (clk),
      .nrst        (nrst),
      .mode        (pin_mode[3:2]),
      .gpio_out    (gpio_out[1]),
      .indicator_n (ind_n[1]),
      .pin_in      (indicator_pins_in[1]),
      .pin_out     (indicator_pins_out[1]),
      .pin_oe      (indicator_pins_oe[1]),
      .gpio_in     (gpio_sync[1])
   );

   // pin 2 carries the duplex indicator
   gli_pin u_pin2 (
      .clk         (clk),
      .nrst        (nrst),
      .mode        (pin_mode[5:4]),
      .gpio_out    (gpio_out[2]),
      .indicator_n (ind_n[2]),
      .pin_in      (indicator_pins_in[2]),
      .pin_out     (indicator_pins_out[2]),
      .pin_oe      (indicator_pins_oe[2]),
      .gpio_in     (gpio_sync[2])
   );
endmodule
